// File: pfs_pkg.sv
// Shared constants and state types of the power-fail and stop supervisor.
// Assumes a 20 MHz system clock and an APB register bus.
package pfs_pkg;
   localparam int          CLK_HZ           = 20000000;
   localparam int          RING_HZ          = 8000;
   localparam int          RING_DIV         = CLK_HZ / RING_HZ;
   localparam int          WARN_QUAL_NS     = 10000;
   localparam int          WARN_QUAL_CYC    = (WARN_QUAL_NS + 49) / 50;
   localparam int          XTAL_WARMUP_NS   = 100000;
   localparam int          XTAL_WARMUP_CYC  = (XTAL_WARMUP_NS + 49) / 50;
   localparam int          PIN_RELEASE_CYC  = 16;
   localparam int          PROBE_ON_TICKS   = 2;
   localparam int          PROBE_ALL_TICKS  = 3;
   localparam logic [15:0] RESTART_ADDR     = 16'h8000;
   localparam logic [11:0] OFS_CTRL         = 12'h000;
   localparam logic [11:0] OFS_STATUS       = 12'h004;
   localparam logic [11:0] OFS_MASK         = 12'h008;
   localparam logic [11:0] OFS_WAKE_PERIOD  = 12'h00C;
   localparam logic [11:0] OFS_STATE        = 12'h010;
   localparam int          CTRL_MON_OFF     = 0;
   localparam int          CTRL_STOP        = 1;
   localparam int          CTRL_PROBE_LSB   = 2;
   localparam logic [3:0]  CTRL_RESET       = 4'h1;
   localparam int          EV_WARN          = 0;
   localparam int          EV_WAKE_TIMER    = 1;
   localparam int          EV_PF_RESET      = 2;
   localparam int          EV_IO_WAKE       = 3;
   typedef enum logic [2:0] {
      PFS_POR      = 3'b000,
      PFS_WARMUP   = 3'b001,
      PFS_RUN      = 3'b010,
      PFS_STOP     = 3'b011,
      PFS_PF_WAIT  = 3'b100,
      PFS_PROBE    = 3'b101,
      PFS_EXT_RST  = 3'b110
   } pfs_state_e;
endpackage

// File: pfs_ring_div.sv
// Ring-oscillator tick generator: one-cycle pulse at the 8 kHz ring rate.
// Assumes the single 20 MHz system clock.
`timescale 1ns/10ps
module pfs_ring_div
(
   input  wire logic clk,
   input  wire logic rst,
   output logic      tick
);
   typedef struct packed
   {
      logic [11:0] cnt;
      logic        tick;
   } pfs_div_s;
   pfs_div_s q;
   pfs_div_s next_q;
   always_comb
   begin
      next_q = q;
      next_q.tick = 1'b0;
      if (q.cnt == 12'(pfs_pkg::RING_DIV - 1))
      begin
         next_q.cnt = 12'h000;
         next_q.tick = 1'b1;
      end
      else
      begin
         next_q.cnt = q.cnt + 12'h001;
      end
   end
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         q <= '0;
      end
      else
      begin
         q <= next_q;
      end
   end
   assign tick = q.tick;
endmodule

// File: pfs_supervisor.sv
// Power-fail and stop-mode supervisor with APB registers and one interrupt.
// Assumes comparator inputs already synchronous to clk, ring rate from a divider.
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/10ps
module pfs_supervisor
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire logic        below_por,
   input  wire logic        below_reset,
   input  wire logic        below_warning,
   input  wire logic        ext_reset_req,
   input  wire logic        wdt_reset_req,
   input  wire logic        io_wake,
   output logic             cpu_reset,
   output logic             cpu_halt,
   output logic [15:0]      restart_addr,
   output logic             monitor_en,
   output logic             regulator_en,
   output logic             xtal_en,
   output logic             sram_retain,
   output logic             pins_hiz,
   output logic             irq
);
   typedef struct packed
   {
      pfs_pkg::pfs_state_e st;
      logic [3:0]          ctrl;
      logic [3:0]          status;
      logic [3:0]          mask;
      logic [15:0]         wake_period;
      logic [15:0]         wake_cnt;
      logic [13:0]         tick_cnt;
      logic [12:0]         cyc_cnt;
      logic [12:0]         qual_cnt;
      logic                stop_wake;
      logic                pf_origin;
      logic                pready;
      logic [31:0]         prdata;
      logic                pslverr;
      logic                cpu_reset;
      logic                cpu_halt;
      logic [15:0]         restart_addr;
      logic                monitor_en;
      logic                regulator_en;
      logic                xtal_en;
      logic                sram_retain;
      logic                pins_hiz;
      logic                irq;
   } pfs_top_s;
   pfs_top_s q;
   pfs_top_s next_q;
   logic     ring_tick;
   pfs_ring_div pfs_ring_div_i
   (
      .clk  (clk),
      .rst  (rst),
      .tick (ring_tick)
   );
   ////////////////////////////////////////////////////////////////////////////////////////////////
   function automatic logic [13:0] probe_period(input logic [1:0] sel);
      logic [13:0] p;
      p = 14'h0000;
      unique case (sel)
         2'b00: p = 14'h0001;
         2'b01: p = 14'h0800;
         2'b10: p = 14'h1000;
         2'b11: p = 14'h2000;
      endcase
      return p;
   endfunction
   ////////////////////////////////////////////////////////////////////////////////////////////////
   logic       acc;
   logic       wr;
   logic [3:0] ev;
   logic       mon_live;
   logic       reset_src;
   always_comb
   begin
      next_q = q;
      ev = 4'h0;
      acc = psel && penable && !q.pready;
      wr = acc && pwrite;
      reset_src = ext_reset_req || wdt_reset_req;
      // Monitor may sleep in stop with the off bit set, in PFS_POR, and in PFS_PF_WAIT when the probe select is nonzero.
      mon_live = !(q.st == pfs_pkg::PFS_STOP && q.ctrl[pfs_pkg::CTRL_MON_OFF]);
      // APB: every access answers one cycle after the access phase begins.
      next_q.pready = acc;
      next_q.pslverr = 1'b0;
      next_q.prdata = 32'h0000_0000;
      if (acc)
      begin
         unique case (paddr)
            pfs_pkg::OFS_CTRL:
            begin
               next_q.prdata = {28'h0, q.ctrl};
               if (wr)
               begin
                  next_q.ctrl = pwdata[3:0];
               end
            end
            pfs_pkg::OFS_STATUS:
            begin
               next_q.prdata = {28'h0, q.status};
            end
            pfs_pkg::OFS_MASK:
            begin
               next_q.prdata = {28'h0, q.mask};
               if (wr)
               begin
                  next_q.mask = pwdata[3:0];
               end
            end
            pfs_pkg::OFS_WAKE_PERIOD:
            begin
               next_q.prdata = {16'h0, q.wake_period};
               if (wr)
               begin
                  next_q.wake_period = pwdata[15:0];
               end
            end
            pfs_pkg::OFS_STATE:
            begin
               next_q.prdata = {29'h0, q.st};
            end
            default:
            begin
               next_q.pslverr = 1'b1;
            end
         endcase
      end
      // A below-warning or below-reset level must persist for the qualify time in run, stop and warmup, so short dips raise nothing.
      if (mon_live && (below_warning || below_reset) && (q.st == pfs_pkg::PFS_RUN
          || q.st == pfs_pkg::PFS_STOP || q.st == pfs_pkg::PFS_WARMUP))
      begin
         if (q.qual_cnt < 13'(pfs_pkg::WARN_QUAL_CYC))
         begin
            next_q.qual_cnt = q.qual_cnt + 13'h0001;
         end
         else if (!below_reset)
         begin
            ev[pfs_pkg::EV_WARN] = 1'b1;
         end
      end
      else
      begin
         next_q.qual_cnt = 13'h0000;
      end
      unique case (q.st)
         pfs_pkg::PFS_POR:
         begin
            next_q.cyc_cnt = 13'h0000;
            if (!below_por)
            begin
               next_q.st = pfs_pkg::PFS_WARMUP;
            end
         end
         pfs_pkg::PFS_WARMUP:
         begin
            if (q.cyc_cnt >= 13'(pfs_pkg::XTAL_WARMUP_CYC))
            begin
               next_q.st = pfs_pkg::PFS_RUN;
               next_q.cyc_cnt = 13'h0000;
               next_q.stop_wake = 1'b0;
            end
            else
            begin
               next_q.cyc_cnt = q.cyc_cnt + 13'h0001;
            end
         end
         pfs_pkg::PFS_RUN:
         begin
            if (reset_src)
            begin
               next_q.st = pfs_pkg::PFS_EXT_RST;
            end
            else if (q.ctrl[pfs_pkg::CTRL_STOP])
            begin
               next_q.st = pfs_pkg::PFS_STOP;
               next_q.wake_cnt = 16'h0000;
            end
         end
         pfs_pkg::PFS_STOP:
         begin
            if (ring_tick)
            begin
               next_q.wake_cnt = q.wake_cnt + 16'h0001;
            end
            if (q.wake_period != 16'h0000 && q.wake_cnt >= q.wake_period)
            begin
               ev[pfs_pkg::EV_WAKE_TIMER] = 1'b1;
            end
            if (io_wake)
            begin
               ev[pfs_pkg::EV_IO_WAKE] = 1'b1;
            end
            if (ev[pfs_pkg::EV_WAKE_TIMER] || io_wake || ev[pfs_pkg::EV_WARN])
            begin
               next_q.st = pfs_pkg::PFS_WARMUP;
               next_q.ctrl[pfs_pkg::CTRL_STOP] = 1'b0;
               next_q.stop_wake = 1'b1;
               next_q.cyc_cnt = 13'h0000;
            end
         end
         pfs_pkg::PFS_EXT_RST:
         begin
            next_q.cyc_cnt = 13'h0000;
            if (!reset_src)
            begin
               next_q.st = pfs_pkg::PFS_PROBE;
            end
         end
         pfs_pkg::PFS_PF_WAIT:
         begin
            if (ring_tick)
            begin
               next_q.tick_cnt = q.tick_cnt + 14'h0001;
               if (q.tick_cnt + 14'h0001 >= probe_period(q.ctrl[3:2]))
               begin
                  next_q.st = pfs_pkg::PFS_PROBE;
                  next_q.tick_cnt = 14'h0000;
               end
            end
         end
         pfs_pkg::PFS_PROBE:
         begin
            if (q.pf_origin)
            begin
               if (below_reset)
               begin
                  next_q.st = pfs_pkg::PFS_PF_WAIT;
                  next_q.tick_cnt = 14'h0000;
               end
               else if (ring_tick)
               begin
                  next_q.tick_cnt = q.tick_cnt + 14'h0001;
                  if (q.tick_cnt + 14'h0001 >= 14'(pfs_pkg::PROBE_ALL_TICKS))
                  begin
                     next_q.st = pfs_pkg::PFS_WARMUP;
                     next_q.cyc_cnt = 13'h0000;
                  end
               end
            end
            else if (q.cyc_cnt >= 13'(pfs_pkg::PIN_RELEASE_CYC))
            begin
               next_q.st = pfs_pkg::PFS_RUN;
            end
            else
            begin
               next_q.cyc_cnt = q.cyc_cnt + 13'h0001;
            end
         end
         default:
         begin
            next_q.st = pfs_pkg::PFS_POR;
         end
      endcase
      // A qualified drop below reset threshold forces the power-fail reset.
      if ((q.st == pfs_pkg::PFS_RUN || q.st == pfs_pkg::PFS_STOP
           || (q.st == pfs_pkg::PFS_WARMUP && q.stop_wake)) && mon_live && below_reset
          && q.qual_cnt >= 13'(pfs_pkg::WARN_QUAL_CYC))
      begin
         next_q.st = pfs_pkg::PFS_PF_WAIT;
         next_q.stop_wake = 1'b0;
         next_q.tick_cnt = 14'h0000;
         next_q.pf_origin = 1'b1;
         next_q.ctrl[pfs_pkg::CTRL_STOP] = 1'b0;
         ev[pfs_pkg::EV_PF_RESET] = 1'b1;
      end
      if (q.st == pfs_pkg::PFS_EXT_RST)
      begin
         next_q.pf_origin = 1'b0;
      end
      if (below_por)
      begin
         next_q.st = pfs_pkg::PFS_POR;
         next_q.pf_origin = 1'b0;
         next_q.stop_wake = 1'b0;
      end
      // Set beats a simultaneous write-one-to-clear.
      if (wr && paddr == pfs_pkg::OFS_STATUS)
      begin
         next_q.status = q.status & ~pwdata[3:0];
      end
      next_q.status = next_q.status | ev;
      next_q.irq = |(next_q.status & q.mask);
      // Power control outputs per state.
      // A wake from stop warms the crystal with the CPU halted, never reset, so state survives.
      next_q.cpu_halt = next_q.st == pfs_pkg::PFS_STOP
                        || (next_q.st == pfs_pkg::PFS_WARMUP && next_q.stop_wake);
      next_q.cpu_reset = !(next_q.st == pfs_pkg::PFS_RUN || next_q.cpu_halt);
      next_q.pins_hiz = next_q.cpu_reset;
      next_q.regulator_en = !(next_q.st == pfs_pkg::PFS_POR || next_q.st == pfs_pkg::PFS_STOP
                              || next_q.st == pfs_pkg::PFS_PF_WAIT
                              || (next_q.st == pfs_pkg::PFS_PROBE && next_q.pf_origin));
      next_q.xtal_en = next_q.regulator_en;
      next_q.sram_retain = next_q.st == pfs_pkg::PFS_STOP || next_q.st == pfs_pkg::PFS_PF_WAIT
                           || next_q.st == pfs_pkg::PFS_PROBE;
      next_q.monitor_en = !(next_q.st == pfs_pkg::PFS_POR
                            || (next_q.st == pfs_pkg::PFS_PF_WAIT && q.ctrl[3:2] != 2'b00)
                            || (next_q.st == pfs_pkg::PFS_STOP
                                && next_q.ctrl[pfs_pkg::CTRL_MON_OFF]));
      if (q.pf_origin && next_q.st == pfs_pkg::PFS_RUN)
      begin
         next_q.restart_addr = pfs_pkg::RESTART_ADDR;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         q <= '0;
         q.st <= pfs_pkg::PFS_POR;
         q.ctrl <= pfs_pkg::CTRL_RESET;
         q.cpu_reset <= 1'b1;
         q.pins_hiz <= 1'b1;
      end
      else
      begin
         q <= next_q;
      end
   end
   assign pready = q.pready;
   assign prdata = q.prdata;
   assign pslverr = q.pslverr;
   assign cpu_reset = q.cpu_reset;
   assign cpu_halt = q.cpu_halt;
   assign restart_addr = q.restart_addr;
   assign monitor_en = q.monitor_en;
   assign regulator_en = q.regulator_en;
   assign xtal_en = q.xtal_en;
   assign sram_retain = q.sram_retain;
   assign pins_hiz = q.pins_hiz;
   assign irq = q.irq;
endmodule

// File: pfs_monitor.sv
// Port assertions for the power-fail and stop supervisor.
// Assumes binding into pfs_supervisor with its single clock and sync reset.
`timescale 1ns/10ps
module pfs_monitor
(
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        below_por,
   input wire logic        below_reset,
   input wire logic        ext_reset_req,
   input wire logic        wdt_reset_req,
   input wire logic        cpu_reset,
   input wire logic        cpu_halt,
   input wire logic [15:0] restart_addr,
   input wire logic        monitor_en,
   input wire logic        regulator_en,
   input wire logic        xtal_en,
   input wire logic        sram_retain,
   input wire logic        pins_hiz,
   input wire logic        irq
);
   // Two cycles of slack because the crystal enable may lag the state change.
   localparam int WARM = 1998;
   // A below-reset level held for the qualify time must bring the power-fail reset.
   localparam int QUAL = 200;
   logic       [11:0] xcnt;
   logic       [12:0] pcnt;
   logic              ext;
   assign ext = ext_reset_req || wdt_reset_req;
   always_ff @(posedge clk)
   begin
      xcnt <= (rst || !xtal_en) ? 12'h000 : xcnt + {11'h000, xcnt != 12'hFFF};
   end
   always_ff @(posedge clk)
   begin
      pcnt <= (rst || !below_reset || below_por || !monitor_en || cpu_reset || cpu_halt || ext)
              ? 13'h0000 : pcnt + {12'h000, pcnt != 13'h1FFF};
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////
   chk_apb_answer: assert property (psel && penable && !pready |=> pready)
      else $error("pready late");
   chk_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
   chk_err_ready: assert property (pslverr |-> pready) else $error("stray pslverr");
   chk_por_hold: assert property (below_por |-> ##[1:2] cpu_reset)
      else $error("no reset below por");
   chk_reset_hiz: assert property (cpu_reset && $past(cpu_reset) |-> pins_hiz)
      else $error("pins driven in reset");
   chk_ext_power: assert property (ext && $past(ext) && $past(regulator_en) && !below_reset
      && !below_por |-> regulator_en && xtal_en && monitor_en) else $error("power off in reset");
   chk_ext_release: assert property ($fell(ext) && cpu_reset && xtal_en
      |-> ##[1:19] !cpu_reset) else $error("slow release");
   chk_pf_power: assert property (pcnt == QUAL |-> ##[1:2] (cpu_reset && !regulator_en
      && !xtal_en && sram_retain)) else $error("power fail not handled");
   chk_stop_quiet: assert property (cpu_halt && !monitor_en && !below_por && !ext
      |=> !cpu_reset) else $error("reset with monitor off");
   chk_monitor_on: assert property (!monitor_en && !cpu_reset |-> cpu_halt)
      else $error("monitor off while running");
   chk_restart_val: assert property ($changed(restart_addr) |-> restart_addr == 16'h8000)
      else $error("bad restart address");
   chk_warm_len: assert property ($fell(cpu_reset) |-> xcnt >= WARM)
      else $error("warmup too short");
   cover property ($fell(cpu_halt));
   cover property ($rose(irq));
   cover property ($changed(restart_addr));
endmodule
bind pfs_supervisor pfs_monitor pfs_monitor_i (.*);

// File: pfs_supervisor_tb_top.sv
// Self-checking bench for the power-fail and stop supervisor.
// Assumes the bound port checker; the bench plays comparators and APB master.
`timescale 1ns/10ps
module pfs_supervisor_tb_top;
   logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
   logic        below_por, below_reset, below_warning, ext_reset_req, wdt_reset_req;
   logic        io_wake, cpu_reset, cpu_halt, monitor_en, regulator_en, xtal_en;
   logic        sram_retain, pins_hiz, irq;
   logic [11:0] paddr;
   logic [15:0] restart_addr;
   logic [31:0] pwdata, prdata, rd;
   int          num_errors = 0;
   int          compares = 0;
   int          cyc = 0;
   int          n;
   pfs_supervisor pfs_supervisor_i (.*);
   always #25 clk = ~clk;
   ////////////////////////////////////////////////////////////
   task final_report();
      if (num_errors == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         num_errors++;
         $display("mismatch at %0t: timeout", $time);
         final_report();
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      compares++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && k < 20)
      begin
         @(posedge clk);
         k++;
      end
      chk(k < 20, 1, "no pready");
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Counts cycles until cpu_reset (sel 0) or cpu_halt (sel 1) is low.
   task wait_low(input int sel, input int lim);
      n = 0;
      while ((sel == 0 ? cpu_reset : cpu_halt) !== 1'b0 && n < lim)
      begin
         @(posedge clk);
         n++;
      end
   endtask
   ////////////////////////////////////////////////////////////
   task t_boot();
      chk({cpu_reset, pins_hiz, regulator_en}, 32'h6, "por state");
      apb(0, pfs_pkg::OFS_CTRL, 32'h0);
      chk(rd, 32'h1, "ctrl reset value");
      below_por <= 1'b0;
      repeat (5) @(posedge clk);
      chk({regulator_en, xtal_en, cpu_reset}, 32'h7, "warmup power");
      wait_low(0, 4000);
      chk(n >= 1990 && n < 4000, 1, "warmup length");
      repeat (2) @(posedge clk);
      chk(pins_hiz, 0, "pins still hiz");
   endtask
   task t_warn();
      apb(1, pfs_pkg::OFS_MASK, 32'hF);
      {below_warning, below_reset} <= 2'b11;
      repeat (150) @(posedge clk);
      {below_warning, below_reset} <= 2'b00;
      apb(0, pfs_pkg::OFS_STATUS, 32'h0);
      chk({irq, rd[2], rd[0], cpu_reset}, 32'h0, "short dip flagged");
      below_warning <= 1'b1;
      repeat (600) @(posedge clk);
      apb(0, pfs_pkg::OFS_STATUS, 32'h0);
      chk(rd, 32'h1, "warning not set");
      chk({irq, cpu_reset}, 32'h2, "warning irq");
      below_warning <= 1'b0;
      apb(1, pfs_pkg::OFS_STATUS, 32'h1);
      apb(0, pfs_pkg::OFS_STATUS, 32'h0);
      chk({irq, rd[0]}, 32'h0, "warning not cleared");
      apb(0, 12'hFFC, 32'h0);
      chk({err, rd[30:0]}, 32'h80000000, "unmapped access");
   endtask
   task t_ext();
      for (int i = 0; i < 2; i++)
      begin
         @(posedge clk);
         ext_reset_req <= (i == 0);
         wdt_reset_req <= (i == 1);
         repeat (10) @(posedge clk);
         chk({cpu_reset, regulator_en, xtal_en, monitor_en}, 32'hF, "power in reset");
         ext_reset_req <= 1'b0;
         wdt_reset_req <= 1'b0;
         @(posedge clk);
         wait_low(0, 40);
         chk(n < 20, 1, "slow release");
      end
   endtask
   task t_stop(input logic [31:0] ctrl, input logic [31:0] per);
      apb(1, pfs_pkg::OFS_WAKE_PERIOD, per);
      apb(1, pfs_pkg::OFS_CTRL, ctrl);
      repeat (3) @(posedge clk);
      chk({cpu_halt, monitor_en}, {30'h0, 1'b1, !ctrl[0]}, "stop entry");
   endtask
   task t_stop_timer();
      t_stop(32'h2, 32'h1);
      wait_low(1, 6000);
      apb(0, pfs_pkg::OFS_STATUS, 32'h0);
      chk({n < 6000, rd[1]}, 32'h3, "timer wake");
      apb(1, pfs_pkg::OFS_STATUS, 32'hF);
   endtask
   task t_stop_io();
      t_stop(32'h3, 32'h0);
      below_reset <= 1'b1;
      below_warning <= 1'b1;
      repeat (50) @(posedge clk);
      chk(cpu_reset, 0, "reset with monitor off");
      below_reset <= 1'b0;
      io_wake <= 1'b1;
      @(posedge clk);
      wait_low(1, 6000);
      io_wake <= 1'b0;
      apb(0, pfs_pkg::OFS_STATUS, 32'h0);
      chk({n < 6000, rd[3], rd[0]}, 32'h7, "io wake in warning band");
      below_warning <= 1'b0;
      apb(1, pfs_pkg::OFS_STATUS, 32'hF);
   endtask
   task t_pf();
      apb(1, pfs_pkg::OFS_CTRL, 32'h0);
      below_reset <= 1'b1;
      below_warning <= 1'b1;
      repeat (203) @(posedge clk);
      chk({cpu_reset, regulator_en, xtal_en, sram_retain}, 32'h9, "power fail");
      repeat (100) @(posedge clk);
      below_reset <= 1'b0;
      below_warning <= 1'b0;
      @(posedge clk);
      wait_low(0, 20000);
      chk(n >= 6900 && n < 20000, 1, "probe recovery");
      chk(restart_addr, 32'h8000, "restart address");
      apb(0, pfs_pkg::OFS_STATUS, 32'h0);
      chk(rd[2], 1, "power fail flag");
      apb(1, pfs_pkg::OFS_CTRL, 32'hC);
      below_reset <= 1'b1;
      repeat (205) @(posedge clk);
      apb(0, pfs_pkg::OFS_CTRL, 32'h0);
      chk({cpu_reset, rd[3:2]}, 32'h7, "probe interval lost");
   endtask
   ////////////////////////////////////////////////////////////
   initial
   begin
      {clk, psel, penable, pwrite, paddr, pwdata} = '0;
      {below_reset, below_warning, ext_reset_req, wdt_reset_req, io_wake} = '0;
      rst = 1'b1;
      below_por = 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_boot();
      t_warn();
      t_ext();
      t_stop_timer();
      t_stop_io();
      t_pf();
      final_report();
   end
endmodule
